// >>> shared/rgbd_pkg.sv
// Shared types and constants for the red and red-green block texture decoder.
package rgbd_pkg;
   // The four block formats that the decoder understands.
   typedef enum logic [1:0] {
      UNSIGNED_RED_BLOCK_FORMAT = 2'h0,
      SIGNED_RED_BLOCK_FORMAT = 2'h1,
      UNSIGNED_RED_GREEN_BLOCK_FORMAT = 2'h2,
      SIGNED_RED_GREEN_BLOCK_FORMAT = 2'h3
   } rgbd_fmt_e;

   // Control states, Gray coded along idle, fetch, wait, push.
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_FETCH = 2'h1,
      ST_WAIT = 2'h3,
      ST_PUSH = 2'h2
   } rgbd_state_e;

   // One texel lookup from the sampler.
   typedef struct packed {
      logic [31:0] base;
      logic [15:0] width;
      logic [15:0] x;
      logic [15:0] y;
      rgbd_fmt_e fmt;
   } rgbd_req_s;

   // One decoded texel, each channel signed fixed point with 14 fraction bits.
   typedef struct packed {
      logic [15:0] r;
      logic [15:0] g;
      logic [15:0] b;
      logic [15:0] a;
   } rgbd_texel_s;

   // Block geometry and layout.
   localparam int BLOCK_DIM = 4;
   localparam int BLOCK_DIM_LOG2 = 2;
   localparam int BYTES_LOG2_ONE = 3;
   localparam int BYTES_LOG2_TWO = 4;
   localparam int CHAN_BITS = 64;
   localparam int CODE_LSB = 16;
   localparam int CODE_BITS = 3;
   localparam logic [7:0] SNORM_MOST_NEG = 8'h80;
   localparam logic signed [9:0] SNORM_REMAP = -10'sd127;

   // Interpolation divisors and endpoint scales.
   localparam int DIV_HI = 7;
   localparam int DIV_LO = 5;
   localparam int UNORM_SCALE = 255;
   localparam int SNORM_SCALE = 127;
   localparam int ONE_INT = 16384;
   localparam logic [15:0] ONE_Q = 16'h4000;
   localparam logic [15:0] MINUS_ONE_Q = 16'hC000;
   localparam logic [15:0] ZERO_Q = 16'h0000;

   // Reset values and buffer depth.
   localparam rgbd_state_e STATE_RESET = ST_IDLE;
   localparam int FIFO_DEPTH = 16;
endpackage

// >>> core/rgbd_fifo.sv
// Parameterised FIFO with a registered head word for decoded texels.
`timescale 1ns/1ns
`default_nettype none
module rgbd_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 16
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] count_q;
   logic out_valid_q;
   logic [WIDTH-1:0] out_data_q;
   logic push;
   logic load;

   // Ready is honest: it drops once the array holds DEPTH words.
   assign in_ready = (count_q != (AW+1)'(DEPTH));
   assign push = in_valid && in_ready;
   assign load = (count_q != '0) && (!out_valid_q || out_ready);
   assign out_valid = out_valid_q;
   assign out_data = out_data_q;

   // Array write side.
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   // Pointers and occupancy of the array.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (load) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(load);
      end
   end

   // Head register, so the consumer sees flop outputs only.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         out_valid_q <= 1'b0;
         out_data_q <= '0;
      end else if (load) begin
         out_valid_q <= 1'b1;
         out_data_q <= mem_q[rd_ptr_q];
      end else if (out_ready) begin
         out_valid_q <= 1'b0;
      end
   end
endmodule // rgbd_fifo
`default_nettype wire

// >>> core/rgbd_decoder.sv
// Red and red-green block texture decoder: addressing, block fetch and texel decode.
`timescale 1ns/1ns
`default_nettype none
module rgbd_decoder
   import rgbd_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic req_valid,
   output logic req_ready,
   input wire rgbd_req_s req,
   output logic fetch_valid,
   input wire logic fetch_ready,
   output logic [31:0] fetch_addr,
   output logic fetch_wide,
   input wire logic blk_valid,
   output logic blk_ready,
   input wire logic [127:0] blk_data,
   output logic texel_valid,
   input wire logic texel_ready,
   output var rgbd_texel_s texel
);
   rgbd_state_e state_q;
   logic req_ready_q;
   logic fetch_valid_q;
   logic [31:0] fetch_addr_q;
   logic fetch_wide_q;
   logic blk_ready_q;
   logic [127:0] blk_q;
   logic sgn_q;
   logic two_q;
   logic [5:0] pos_q;
   logic [3:0] loc_q;
   logic accept;
   logic is_sgn;
   logic is_two;
   logic [14:0] blocks_per_row;
   logic [28:0] block_index;
   logic [31:0] byte_offset;
   logic [5:0] pos_d;
   logic push_valid;
   logic push_ready;
   rgbd_texel_s texel_d;
   logic [15:0] chan_val [2];
   logic [2:0] chan_code [2];
   logic chan_hi [2];

   assign accept = req_valid && req_ready_q;
   assign is_sgn = (req.fmt == SIGNED_RED_BLOCK_FORMAT) || (req.fmt == SIGNED_RED_GREEN_BLOCK_FORMAT);
   assign is_two = (req.fmt == UNSIGNED_RED_GREEN_BLOCK_FORMAT) || (req.fmt == SIGNED_RED_GREEN_BLOCK_FORMAT);

   // Block address: no clipping, padding blocks are fetched like any other.
   assign blocks_per_row = 15'((17'(req.width) + 17'h0_0003) >> BLOCK_DIM_LOG2);
   assign block_index = 29'(blocks_per_row * (req.y >> BLOCK_DIM_LOG2)) + 29'(req.x >> BLOCK_DIM_LOG2);
   assign byte_offset = is_two ? 32'(block_index) << BYTES_LOG2_TWO
                               : 32'(block_index) << BYTES_LOG2_ONE;

   // Local texel 4y+x picks a 3-bit field; times three is a shift plus add.
   assign pos_d = {req.y[1:0], req.x[1:0], 1'b0} + {2'b00, req.y[1:0], req.x[1:0]};

   // Control sequence: take request, fetch block, wait for bytes, push texel.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_q <= STATE_RESET;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (accept) state_q <= ST_FETCH;
            end
            ST_FETCH: begin
               if (fetch_ready) state_q <= ST_WAIT;
            end
            ST_WAIT: begin
               if (blk_valid) state_q <= ST_PUSH;
            end
            ST_PUSH: begin
               if (push_ready) state_q <= ST_IDLE;
            end
            default: state_q <= STATE_RESET;
         endcase
      end
   end

   // Request side handshake; one lookup is in flight at a time.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         req_ready_q <= 1'b1;
      end else if (accept) begin
         req_ready_q <= 1'b0;
      end else if (state_q == ST_PUSH && push_ready) begin
         req_ready_q <= 1'b1;
      end
   end

   // Lookup context kept for the decode step.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sgn_q <= 1'b0;
         two_q <= 1'b0;
         pos_q <= '0;
         loc_q <= '0;
      end else if (accept) begin
         sgn_q <= is_sgn;
         two_q <= is_two;
         pos_q <= pos_d;
         loc_q <= {req.y[1:0], req.x[1:0]}; // Raw local position, kept only for the code check.
      end
   end

   // Fetch request to the memory side, held until taken.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         fetch_valid_q <= 1'b0;
         fetch_addr_q <= '0;
         fetch_wide_q <= 1'b0;
      end else if (accept) begin
         fetch_valid_q <= 1'b1;
         fetch_addr_q <= req.base + byte_offset;
         fetch_wide_q <= is_two;
      end else if (fetch_ready) begin
         fetch_valid_q <= 1'b0;
      end
   end

   // Block bytes arrive after the fetch is taken; only the low half matters for one channel.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         blk_ready_q <= 1'b0;
         blk_q <= '0;
      end else begin
         if (state_q == ST_FETCH && fetch_ready) begin
            blk_ready_q <= 1'b1;
         end else if (blk_valid) begin
            blk_ready_q <= 1'b0;
         end
         if (state_q == ST_WAIT && blk_valid) begin
            blk_q <= blk_data;
         end
      end
   end

   // Rounds num*ONE/den half away from zero, so equal inputs always give equal outputs.
   function automatic logic [15:0] scale_q(input int num, input int den);
      int mag;
      int q;
      mag = (num < 0) ? -num : num;
      q = (mag * ONE_INT + den / 2) / den;
      return (num < 0) ? 16'(-q) : 16'(q);
   endfunction

   // Both channel halves decode the same way; red is the low 64 bits.
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      logic [63:0] raw;
      logic [47:0] bits;
      logic signed [9:0] e0;
      logic signed [9:0] e1;

      assign raw = blk_q[CHAN_BITS*ch +: CHAN_BITS];
      assign bits = raw[CODE_LSB +: 48];
      assign chan_code[ch] = bits[pos_q +: CODE_BITS];
      // Remapping -128 before the compare is allowed and saves a stage.
      assign e0 = !sgn_q ? {2'b00, raw[7:0]} : (raw[7:0] == SNORM_MOST_NEG) ? SNORM_REMAP
                : {{2{raw[7]}}, raw[7:0]};
      assign e1 = !sgn_q ? {2'b00, raw[15:8]} : (raw[15:8] == SNORM_MOST_NEG) ? SNORM_REMAP
                : {{2{raw[15]}}, raw[15:8]};
      assign chan_hi[ch] = e0 > e1;

      // Weights per code; codes 0 and 1 give the endpoints exactly.
      always_comb begin
         int w0;
         int w1;
         int den;
         int c;
         w0 = 0;
         w1 = 0;
         c = int'(chan_code[ch]);
         den = chan_hi[ch] ? DIV_HI : DIV_LO;
         if (c == 0) begin
            w0 = den;
         end else if (c == 1) begin
            w1 = den;
         end else if (chan_hi[ch]) begin
            w0 = 8 - c;
            w1 = c - 1;
         end else begin
            w0 = 6 - c;
            w1 = c - 1;
         end
         chan_val[ch] = scale_q(w0 * int'(e0) + w1 * int'(e1),
                                den * (sgn_q ? SNORM_SCALE : UNORM_SCALE));
         if (!chan_hi[ch] && c == 6) begin
            chan_val[ch] = sgn_q ? MINUS_ONE_Q : ZERO_Q;
         end else if (!chan_hi[ch] && c == 7) begin
            chan_val[ch] = ONE_Q;
         end
      end
   end

   // Texel assembly: green only for the two-channel formats.
   always_comb begin
      texel_d.r = chan_val[0];
      texel_d.g = two_q ? chan_val[1] : ZERO_Q;
      texel_d.b = ZERO_Q;
      texel_d.a = ONE_Q;
   end

   assign push_valid = (state_q == ST_PUSH);

   // The FIFO absorbs output stalls; when full the control sequence waits in push.
   rgbd_fifo #(
      .WIDTH($bits(rgbd_texel_s)),
      .DEPTH(DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(texel_d),
      .out_valid(texel_valid),
      .out_ready(texel_ready),
      .out_data(texel)
   );

   assign req_ready = req_ready_q;
   assign fetch_valid = fetch_valid_q;
   assign fetch_addr = fetch_addr_q;
   assign fetch_wide = fetch_wide_q;
   assign blk_ready = blk_ready_q;

   // Checks on the control sequence and the decoded values.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   fetch_addr_calc_a: assert property (accept |=> fetch_valid_q && fetch_addr_q ==
      32'($past(req.base) + ($past(is_two) ? 16 : 8) * ((($past(req.width) + 3) / 4) * ($past(req.y) / 4)
      + $past(req.x) / 4)))
      else $error("Block address does not match the block grid.");

   fetch_size_a: assert property (accept |=> fetch_wide_q == $past(is_two))
      else $error("Block size does not match the format.");

   fetch_hold_a: assert property (fetch_valid_q && !fetch_ready |=> fetch_valid_q && $stable(fetch_addr_q))
      else $error("Fetch request dropped before it was taken.");

   code_select_a: assert property (push_valid |->
      chan_code[0] == blk_q[CODE_LSB + 3 * int'(loc_q) +: CODE_BITS]
      && chan_code[1] == blk_q[CHAN_BITS + CODE_LSB + 3 * int'(loc_q) +: CODE_BITS])
      else $error("Texel code taken from the wrong bit position.");

   alpha_blue_a: assert property (push_valid |-> texel_d.a == ONE_Q && texel_d.b == ZERO_Q)
      else $error("Blue or alpha channel is not constant.");

   red_only_a: assert property (push_valid && !two_q |-> texel_d.g == ZERO_Q)
      else $error("Single-channel texel has non-zero green.");

   unorm_range_a: assert property (push_valid && !sgn_q |->
      $signed(texel_d.r) >= 0 && $signed(texel_d.r) <= $signed(ONE_Q))
      else $error("Unsigned red left the range zero to one.");

   snorm_range_a: assert property (push_valid && sgn_q |->
      $signed(texel_d.r) >= $signed(MINUS_ONE_Q) && $signed(texel_d.r) <= $signed(ONE_Q))
      else $error("Signed red left the range minus one to one.");

   endpoint_max_a: assert property (push_valid && !sgn_q && blk_q[7:0] == 8'hFF && chan_code[0] == 3'h0
      |-> texel_d.r == ONE_Q)
      else $error("Code zero does not return the first endpoint.");

   snorm_min_a: assert property (push_valid && sgn_q && blk_q[7:0] == SNORM_MOST_NEG && chan_code[0] == 3'h0
      |-> texel_d.r == MINUS_ONE_Q)
      else $error("Endpoint -128 does not decode to minus one.");

   lo_limits_a: assert property (push_valid && !chan_hi[0] && chan_code[0] == 3'h7
      |-> texel_d.r == ONE_Q)
      else $error("Code seven in lower mode is not the upper limit.");

   flow_latency_a: assert property (state_q == ST_FETCH && fetch_ready
      |=> blk_ready_q && !fetch_valid_q && !req_ready_q)
      else $error("Block bytes not requested after the fetch was taken.");

   push_done_a: assert property (push_valid && push_ready |=> state_q == ST_IDLE && req_ready_q)
      else $error("Request side not reopened after the texel was pushed.");

   // Handshake checks: block request and texel stand until taken, block ready only in wait, no new lookup while busy.
   blk_hold_a: assert property (blk_ready_q && !blk_valid |=> blk_ready_q)
      else $error("Block request dropped before the bytes arrived.");

   blk_only_wait_a: assert property (blk_ready_q |-> state_q == ST_WAIT)
      else $error("Block bytes requested outside the wait state.");

   req_stall_a: assert property (state_q != ST_IDLE |-> !req_ready_q)
      else $error("New lookup offered while one is still in flight.");

   texel_hold_a: assert property (texel_valid && !texel_ready |=> texel_valid && $stable(texel))
      else $error("Texel changed or vanished before it was taken.");

   // Mode choice is checked on the raw endpoint bytes, so a slip in the widening logic shows up.
   unorm_mode_a: assert property (push_valid && !sgn_q |->
      chan_hi[0] == (blk_q[7:0] > blk_q[15:8]) && chan_hi[1] == (blk_q[71:64] > blk_q[79:72]))
      else $error("Unsigned interpolation mode chosen wrongly.");

   snorm_mode_a: assert property (push_valid && sgn_q |->
      chan_hi[0] == ($signed((blk_q[7:0] == 8'h80) ? 8'h81 : blk_q[7:0])
      > $signed((blk_q[15:8] == 8'h80) ? 8'h81 : blk_q[15:8])))
      else $error("Signed interpolation mode chosen wrongly.");

   snorm_max_a: assert property (push_valid && sgn_q && blk_q[7:0] == 8'h7F && chan_code[0] == 3'h0
      |-> texel_d.r == ONE_Q)
      else $error("Endpoint 127 does not decode to one.");

   // Green follows the same limits as red in the lower mode.
   green_limits_a: assert property (push_valid && two_q && !chan_hi[1] && chan_code[1][2:1] == 2'h3
      |-> texel_d.g == (chan_code[1][0] ? ONE_Q : (sgn_q ? MINUS_ONE_Q : ZERO_Q)))
      else $error("Green code six or seven in lower mode is not a limit.");

   // Main scenarios worth seeing in simulation.
   unorm_red_c: cover property (push_valid && push_ready && !sgn_q && !two_q);
   snorm_rg_c: cover property (push_valid && push_ready && sgn_q && two_q);
   lo_code6_c: cover property (push_valid && !chan_hi[0] && chan_code[0] == 3'h6);
   fifo_full_c: cover property (push_valid && !push_ready);
   hi_code7_c: cover property (push_valid && chan_hi[0] && chan_code[0] == 3'h7);
endmodule // rgbd_decoder
`default_nettype wire

// >>> sim/rgbd_mem_model.sv
// Behavioural texture memory that answers block fetches after a chosen delay.
`timescale 1ns/1ns
`default_nettype none
module rgbd_mem_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic fetch_valid,
   output logic fetch_ready,
   input wire logic fetch_wide,
   output logic blk_valid,
   input wire logic blk_ready,
   output logic [127:0] blk_data,
   input wire logic [127:0] blk_src,
   input wire logic [3:0] lat
);
   logic [1:0] st_q;
   logic [3:0] cnt_q;
   logic wide_q;

   // Take a fetch, wait, then offer the block; released bytes are inverted so stale data never looks valid.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         st_q <= 2'h0;
         fetch_ready <= 1'b0;
         blk_valid <= 1'b0;
         blk_data <= 128'h5a5a_5a5a_5a5a_5a5a_5a5a_5a5a_5a5a_5a5a;
      end else begin
         case (st_q)
            2'h0: if (fetch_valid) begin
               cnt_q <= lat;
               st_q <= 2'h1;
            end
            2'h1: if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
               else begin
                  fetch_ready <= 1'b1;
                  st_q <= 2'h2;
               end
            2'h2: if (fetch_valid && fetch_ready) begin
               fetch_ready <= 1'b0;
               wide_q <= fetch_wide;
               cnt_q <= lat;
               st_q <= 2'h3;
            end
            default: if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
               else if (!blk_valid) begin
                  // A narrow block leaves the upper bytes as junk, so a decoder that reads them shows up.
                  blk_valid <= 1'b1;
                  blk_data <= wide_q ? blk_src : {~blk_src[127:64], blk_src[63:0]};
               end else if (blk_ready) begin
                  blk_valid <= 1'b0;
                  blk_data <= ~blk_data;
                  st_q <= 2'h0;
               end
         endcase
      end
   end
endmodule // rgbd_mem_model
`default_nettype wire

// >>> sim/rg_block_texture_decoder_bench.sv
// Self-checking bench for the block texture decoder with a behavioural memory.
`timescale 1ns/1ns
`default_nettype none
module rg_block_texture_decoder_bench;
   import rgbd_pkg::*;
   localparam int TB_DEPTH = 2;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   logic texel_ready = 1'b0;
   rgbd_req_s req_in = '0;
   logic [127:0] blk_src = '0;
   logic [3:0] lat = 4'h0;
   logic req_ready, fetch_valid, fetch_ready, fetch_wide, blk_valid, blk_ready, texel_valid;
   logic [31:0] fetch_addr;
   logic [127:0] blk_data;
   rgbd_texel_s texel;
   int err_total = 0;
   int compares = 0;
   int cyc = 0;
   logic [63:0] q_tex[$];
   logic [63:0] q_addr[$];
   // Endpoint pairs; the pair -127 then -128 is left out on purpose.
   logic [15:0] ends[5] = '{16'hc820, 16'hffc8, 16'h807f, 16'h7f80, 16'h4040};

   // The clock toggles every half period of 5 ns.
   always #5 core_clk = ~core_clk;

   rgbd_decoder #(.DEPTH(TB_DEPTH)) u_rgbd_decoder (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
      .req_ready(req_ready), .req(req_in), .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
      .fetch_addr(fetch_addr), .fetch_wide(fetch_wide), .blk_valid(blk_valid), .blk_ready(blk_ready),
      .blk_data(blk_data), .texel_valid(texel_valid), .texel_ready(texel_ready), .texel(texel));

   rgbd_mem_model u_rgbd_mem_model (.core_clk(core_clk), .rst_n(rst_n), .fetch_valid(fetch_valid),
      .fetch_ready(fetch_ready), .fetch_wide(fetch_wide), .blk_valid(blk_valid), .blk_ready(blk_ready),
      .blk_data(blk_data), .blk_src(blk_src), .lat(lat));

   task automatic stop_test;
      if (err_total == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Expected channel in Q1.14, rounded half away from zero.
   function automatic logic [15:0] chan(input logic [7:0] e0, input logic [7:0] e1, input int c, input logic sg);
      int a, b, w0, w1, den, n, d, q;
      a = sg ? int'($signed(e0)) : int'(e0);
      b = sg ? int'($signed(e1)) : int'(e1);
      if (a == -128) a = -127;
      if (b == -128) b = -127;
      den = (a > b) ? 7 : 5;
      if (den == 5 && c == 6) return sg ? 16'hc000 : 16'h0000;
      if (den == 5 && c == 7) return 16'h4000;
      w0 = (c == 0) ? den : (c == 1) ? 0 : (den == 7) ? 8 - c : 6 - c;
      w1 = (c == 0) ? 0 : (c == 1) ? den : c - 1;
      n = (w0 * a + w1 * b) * 16384;
      d = den * (sg ? 127 : 255);
      q = ((n < 0 ? -n : n) * 2 + d) / (2 * d);
      return 16'(n < 0 ? -q : q);
   endfunction

   // Each fetch handshake must carry the block address that the lookup implies.
   always @(posedge core_clk) begin
      cyc++;
      if (rst_n && fetch_valid === 1'b1 && fetch_ready === 1'b1) check(64'({fetch_wide, fetch_addr}), q_addr.pop_front());
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end

   // One lookup: builds the block and its expectations, waits for a free decoder, hands the request over.
   task automatic send(input int f, input int s, input int c);
      logic [7:0] e0, e1;
      logic [47:0] v, u;
      int p, x, y, n;
      logic sg, wd;
      rgbd_req_s r;
      e0 = ends[s][15:8];
      e1 = ends[s][7:0];
      sg = f[0];
      wd = f[1];
      p = (c * 5 + s) % 16;
      v = {16{~3'(c)}};
      v[3*p+:3] = 3'(c);
      u = {16{3'(c)}};
      u[3*p+:3] = 3'(c + 3);
      x = 4 * c + p % 4;
      y = 4 * (f * 5 + s) + p / 4;
      r.base = 32'h0010_0000 + 32'(f * 4096);
      r.width = 16'd13;
      r.x = 16'(x);
      r.y = 16'(y);
      r.fmt = rgbd_fmt_e'(f);
      q_addr.push_back(64'({wd, r.base + 32'((wd ? 16 : 8) * (4 * (y / 4) + x / 4))}));
      q_tex.push_back({chan(e0, e1, c, sg), wd ? chan(e1, e0, (c + 3) % 8, sg) : 16'h0000, 16'h0000, 16'h4000});
      n = 0;
      do @(posedge core_clk); while (req_ready !== 1'b1 && ++n < 300);
      req_in <= r;
      blk_src <= {u, e0, e1, v, e1, e0};
      lat <= 4'(c % 3);
      req_valid <= 1'b1;
      @(posedge core_clk);
      req_valid <= 1'b0;
      @(posedge core_clk);
      check(64'(fetch_valid), 64'h1);
      if (n >= 300) err_total++;
   endtask

   // Takes the next texel at the head of the queue and compares it with the oldest expectation.
   task automatic recv;
      int n;
      n = 0;
      @(posedge core_clk);
      texel_ready <= 1'b1;
      do @(posedge core_clk); while (texel_valid !== 1'b1 && ++n < 300);
      check(texel, q_tex.pop_front());
      texel_ready <= 1'b0;
      if (n >= 300) err_total++;
   endtask

   // Outputs straight after reset must be idle and ready.
   task automatic reset_state;
      @(posedge core_clk);
      check(64'({req_ready, fetch_valid, blk_ready, texel_valid}), 64'h8);
      check(texel, 64'h0);
   endtask

   // Every format, endpoint pair and code, one lookup at a time.
   task automatic all_codes;
      for (int f = 0; f < 4; f++) begin
         for (int s = 0; s < 5; s++) begin
            for (int c = 0; c < 8; c++) begin
               send(f, s, c);
               recv();
            end
         end
      end
   endtask

   // Fill the array and the head register with the consumer stalled; one more lookup then waits in push.
   task automatic fill_drain;
      for (int i = 0; i <= TB_DEPTH + 1; i++) send(3 - i % 4, i % 5, 7 - i);
      for (int i = 0; i < 20; i++) begin
         @(posedge core_clk);
         check(64'(req_ready), 64'h0);
      end
      for (int i = 0; i <= TB_DEPTH + 1; i++) recv();
   endtask

   // Main sequence: reset for six cycles, then the scenarios.
   initial begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      reset_state();
      all_codes();
      fill_drain();
      all_codes();
      stop_test();
   end
endmodule // rg_block_texture_decoder_bench
`default_nettype wire
